// ---- rtl/counter16_byte_access_unit.sv ----
/*
 * 16-bit up/down counter with byte-wide CPU access through a shared high-byte
 * temporary register, mode driven TOP/BOTTOM and an overflow flag.
 * Assumes an 8-bit I/O bus with one select per byte location and one access
 * per cycle; compare and capture units sit outside and share the temporary
 * register through the temp load port.
 */
// Notes on behaviour
// - Counter is a 16-bit up/down counter, direction from an internal select.
// - Counter seen by CPU as separate high and low byte locations.
// - High byte location accesses only the temporary register.
// - Reading the low byte copies counter high byte into temp same cycle.
// - Writing the low byte loads temp and written byte together in one cycle.
// - Temp holds its value until rewritten, so one high byte serves many writes.
// - Timer clock comes from internal or external source by 3-bit select.
// - Select code zero gives no clock and the counter stands still.
// - CPU may read and write the counter with or without a timer clock.
// - A CPU counter write beats any clear or count in that cycle.
// - Each timer clock clears, increments or decrements as the mode asks.
// - A count step changes the counter by exactly one in the set direction.
// - Clear forces every counter bit to zero.
// - TOP shows when the counter equals the highest value of the sequence.
// - BOTTOM shows when the counter is zero.
// - Sequence chosen by the 4-bit waveform mode field.
// - Overflow flag set where the mode defines, offered as interrupt request.
// - TOP is 0xFFFF, 0x00FF, 0x01FF, 0x03FF, compare A or capture value by mode.
// - Compare register reads neither use nor change the temporary register.
`timescale 1ns/1ns
`default_nettype none

module counter16_byte_access_unit
    import counter16_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic io_low_sel_in,
    input wire logic io_high_sel_in,
    input wire logic io_rd_in,
    input wire logic io_wr_in,
    input wire logic [7:0] io_wdata_in,
    output logic [7:0] io_rdata_out,
    input wire logic [2:0] clock_select_field_in,
    input wire logic [3:0] waveform_mode_field_in,
    input wire logic ext_clock_pin_in,
    input wire logic [15:0] compare_a_in,
    input wire logic [15:0] capture_in,
    input wire logic temp_load_in,
    input wire logic [7:0] temp_load_data_in,
    output logic [7:0] temp_byte_out,
    input wire logic overflow_clear_in,
    input wire logic overflow_ack_in,
    input wire logic overflow_irq_en_in,
    output logic [15:0] timer_count_value_out,
    output logic timer_clock_out,
    output logic top_out,
    output logic bottom_out,
    output logic direction_down_out,
    output logic overflow_flag_out,
    output logic overflow_irq_out
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [BYTE_W-1:0] temp;
        logic [BYTE_W-1:0] rdata;
        dir_e dir;
        logic ovf;
    } unit_state_s;

    unit_state_s st_q;
    unit_state_s st_d;

    // ------------------------------------------------------------------
    // Mode decoding
    // ------------------------------------------------------------------
    // Slope class of a waveform mode; used by the count and flag logic
    function automatic slope_e mode_slope(input logic [3:0] mode);
        logic [4:0] entry;
        entry = MODE_TABLE[mode];
        return slope_e'(entry[4:3]);
    endfunction : mode_slope

    // TOP of a waveform mode; compare A or capture come from outside units
    function automatic logic [15:0] mode_top(
        input logic [3:0] mode,
        input logic [15:0] cmpa,
        input logic [15:0] capt
    );
        logic [4:0] entry;
        logic [15:0] top;
        entry = MODE_TABLE[mode];
        case (top_src_e'(entry[2:0]))
            TOP_MAX: top = MAX_VALUE;
            TOP_8: top = TOP_FIX8;
            TOP_9: top = TOP_FIX9;
            TOP_10: top = TOP_FIX10;
            TOP_CMPA: top = cmpa;
            TOP_CAPT: top = capt;
            default: top = MAX_VALUE;
        endcase
        return top;
    endfunction : mode_top

    slope_e slope;
    logic [15:0] top_value;
    logic at_top;
    logic at_bottom;
    logic at_max;

    // Sequence limits from the current mode and counter
    always_comb begin
        slope = mode_slope(waveform_mode_field_in);
        top_value = mode_top(waveform_mode_field_in, compare_a_in, capture_in);
        at_top = (st_q.cnt == top_value);
        at_bottom = (st_q.cnt == BOTTOM_VALUE);
        at_max = (st_q.cnt == MAX_VALUE);
    end

    // ------------------------------------------------------------------
    // Timer clock selection
    // ------------------------------------------------------------------
    timer_clock_if tc_bus ();

    // The selector only produces a count enable, never a clock edge
    assign tc_bus.ce = ce_in;
    assign tc_bus.clock_select_field = clock_select_field_in;
    assign tc_bus.ext_pin = ext_clock_pin_in;

    timer_clock_select u_clock_select (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .tc(tc_bus.sel)
    );

    logic tick;
    assign tick = tc_bus.tick;

    // ------------------------------------------------------------------
    // CPU access decode
    // ------------------------------------------------------------------
    // A write and a read in one cycle is treated as a write
    logic wr_low;
    logic wr_high;
    logic rd_low;
    logic rd_high;

    always_comb begin
        wr_low = io_low_sel_in && io_wr_in;
        wr_high = io_high_sel_in && io_wr_in;
        rd_low = io_low_sel_in && io_rd_in && !io_wr_in;
        rd_high = io_high_sel_in && io_rd_in && !io_wr_in;
    end

    // ------------------------------------------------------------------
    // Count step
    // ------------------------------------------------------------------
    logic [15:0] cnt_step;
    dir_e dir_step;
    logic ovf_event;

    // Next counter value for one timer clock, ignoring CPU writes
    always_comb begin
        cnt_step = st_q.cnt;
        dir_step = st_q.dir;
        ovf_event = 1'b0;
        case (slope)
            SLOPE_NORMAL: begin
                dir_step = DIR_UP;
                ovf_event = at_max;
                if (at_top) begin
                    cnt_step = BOTTOM_VALUE;
                end else begin
                    cnt_step = st_q.cnt + CNT_STEP;
                end
            end
            SLOPE_FAST: begin
                dir_step = DIR_UP;
                ovf_event = at_top;
                if (at_top) begin
                    cnt_step = BOTTOM_VALUE;
                end else begin
                    cnt_step = st_q.cnt + CNT_STEP;
                end
            end
            SLOPE_DUAL: begin
                ovf_event = at_bottom;
                // Turn round at the ends so TOP and BOTTOM are each seen once
                if (st_q.dir == DIR_UP && at_top) begin
                    dir_step = DIR_DOWN;
                end else if (st_q.dir == DIR_DOWN && at_bottom) begin
                    dir_step = DIR_UP;
                end
                if (dir_step == DIR_UP) begin
                    cnt_step = st_q.cnt + CNT_STEP;
                end else begin
                    cnt_step = st_q.cnt - CNT_STEP;
                end
            end
            default: begin
                cnt_step = st_q.cnt;
                dir_step = st_q.dir;
                ovf_event = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        if (ce_in) begin
            // Counter: CPU low-byte write first, then a timer clock
            if (wr_low) begin
                st_d.cnt = {st_q.temp, io_wdata_in};
            end else if (tick) begin
                st_d.cnt = cnt_step;
                st_d.dir = dir_step;
            end

            // Temporary register: only these causes change it
            if (wr_high) begin
                st_d.temp = io_wdata_in;
            end else if (rd_low) begin
                st_d.temp = st_q.cnt[15:8];
            end else if (temp_load_in) begin
                st_d.temp = temp_load_data_in;
            end

            // Read data is registered; the high location returns temp
            if (rd_low) begin
                st_d.rdata = st_q.cnt[7:0];
            end else if (rd_high) begin
                st_d.rdata = st_q.temp;
            end

            // Overflow flag: a set in the clearing cycle is kept
            if (overflow_clear_in || overflow_ack_in) begin
                st_d.ovf = 1'b0;
            end
            if (tick && !wr_low && ovf_event) begin
                st_d.ovf = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q.cnt <= CNT_RESET;
            st_q.temp <= TEMP_RESET;
            st_q.rdata <= RDATA_RESET;
            st_q.dir <= DIR_UP;
            st_q.ovf <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Flag and data come straight from flip-flops; indications are compares
    always_comb begin
        io_rdata_out = st_q.rdata;
        temp_byte_out = st_q.temp;
        timer_count_value_out = st_q.cnt;
        timer_clock_out = tick;
        top_out = at_top;
        bottom_out = at_bottom;
        direction_down_out = (st_q.dir == DIR_DOWN);
        overflow_flag_out = st_q.ovf;
        overflow_irq_out = st_q.ovf && overflow_irq_en_in;
    end

endmodule : counter16_byte_access_unit

`default_nettype wire

// ---- rtl/counter16_pkg.sv ----
/*
 * Constants and types shared by the 16-bit counter unit and its clock selector.
 * Assumes a single system clock domain; all timer clocks are count enables.
 */
`default_nettype none

package counter16_pkg;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int CNT_W = 16;
    localparam int BYTE_W = 8;
    localparam int PRESC_W = 10;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [7:0] TEMP_RESET = 8'h00;
    localparam logic [7:0] RDATA_RESET = 8'h00;
    localparam logic [9:0] PRESC_RESET = 10'h000;

    // ------------------------------------------------------------------
    // Count sequence limits
    // ------------------------------------------------------------------
    localparam logic [15:0] BOTTOM_VALUE = 16'h0000;
    localparam logic [15:0] MAX_VALUE = 16'hFFFF;
    localparam logic [15:0] TOP_FIX8 = 16'h00FF;
    localparam logic [15:0] TOP_FIX9 = 16'h01FF;
    localparam logic [15:0] TOP_FIX10 = 16'h03FF;
    localparam logic [15:0] CNT_STEP = 16'h0001;

    // ------------------------------------------------------------------
    // Clock select codes and prescaler tap masks
    // ------------------------------------------------------------------
    localparam logic [2:0] CS_NONE = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    localparam logic [9:0] MASK_DIV8 = 10'h007;
    localparam logic [9:0] MASK_DIV64 = 10'h03F;
    localparam logic [9:0] MASK_DIV256 = 10'h0FF;
    localparam logic [9:0] MASK_DIV1024 = 10'h3FF;

    // ------------------------------------------------------------------
    // Mode decoding types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        TOP_MAX = 3'b000,
        TOP_8 = 3'b001,
        TOP_9 = 3'b010,
        TOP_10 = 3'b011,
        TOP_CMPA = 3'b100,
        TOP_CAPT = 3'b101
    } top_src_e;

    typedef enum logic [1:0] {
        SLOPE_NORMAL = 2'b00,
        SLOPE_FAST = 2'b01,
        SLOPE_DUAL = 2'b10
    } slope_e;

    typedef enum logic {
        DIR_UP = 1'b0,
        DIR_DOWN = 1'b1
    } dir_e;

    // Waveform mode table: {slope, top source}, indexed by the 4-bit field.
    // Code 13 is reserved and behaves as normal counting.
    localparam logic [4:0] MODE_TABLE [16] = '{
        {SLOPE_NORMAL, TOP_MAX}, {SLOPE_DUAL, TOP_8}, {SLOPE_DUAL, TOP_9},
        {SLOPE_DUAL, TOP_10}, {SLOPE_NORMAL, TOP_CMPA}, {SLOPE_FAST, TOP_8},
        {SLOPE_FAST, TOP_9}, {SLOPE_FAST, TOP_10}, {SLOPE_DUAL, TOP_CAPT},
        {SLOPE_DUAL, TOP_CMPA}, {SLOPE_DUAL, TOP_CAPT}, {SLOPE_DUAL, TOP_CMPA},
        {SLOPE_NORMAL, TOP_CAPT}, {SLOPE_NORMAL, TOP_MAX}, {SLOPE_FAST, TOP_CAPT},
        {SLOPE_FAST, TOP_CMPA}
    };

endpackage : counter16_pkg

`default_nettype wire

// ---- rtl/timer_clock_if.sv ----
/*
 * Carrier between the counter unit and its timer clock selector.
 * Assumes both ends share the system clock.
 */
`timescale 1ns/1ns
`default_nettype none

interface timer_clock_if;
    logic ce;
    logic [2:0] clock_select_field;
    logic ext_pin;
    logic tick;

    modport sel (
        input ce,
        input clock_select_field,
        input ext_pin,
        output tick
    );

    modport core (
        output ce,
        output clock_select_field,
        output ext_pin,
        input tick
    );
endinterface : timer_clock_if

`default_nettype wire

// ---- rtl/timer_clock_select.sv ----
/*
 * Timer clock selector: free running prescaler plus external pin edge detect,
 * producing a one-cycle count enable. The external pin is taken as already
 * synchronous to the system clock.
 */
`timescale 1ns/1ns
`default_nettype none

module timer_clock_select
    import counter16_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    timer_clock_if.sel tc
);

    typedef struct packed {
        logic [PRESC_W-1:0] presc;
        logic pin;
    } sel_state_s;

    sel_state_s st_q;
    sel_state_s st_d;

    // ------------------------------------------------------------------
    // Tap decode
    // ------------------------------------------------------------------
    // Tick is combinational so the counter moves in the same cycle as the tap
    always_comb begin
        case (tc.clock_select_field)
            CS_NONE: tc.tick = 1'b0;
            CS_DIV1: tc.tick = tc.ce;
            CS_DIV8: tc.tick = tc.ce && ((st_q.presc & MASK_DIV8) == MASK_DIV8);
            CS_DIV64: tc.tick = tc.ce && ((st_q.presc & MASK_DIV64) == MASK_DIV64);
            CS_DIV256: tc.tick = tc.ce && ((st_q.presc & MASK_DIV256) == MASK_DIV256);
            CS_DIV1024: tc.tick = tc.ce && (st_q.presc == MASK_DIV1024);
            CS_EXT_FALL: tc.tick = tc.ce && st_q.pin && !tc.ext_pin;
            CS_EXT_RISE: tc.tick = tc.ce && !st_q.pin && tc.ext_pin;
            default: tc.tick = 1'b0;
        endcase
    end

    // Prescaler runs whenever ce is high, whatever the select code; code zero stops only the tick
    always_comb begin
        st_d = st_q;
        if (tc.ce) begin
            st_d.presc = st_q.presc + 10'h001;
            st_d.pin = tc.ext_pin;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

endmodule : timer_clock_select

`default_nettype wire

// ---- verification/counter16_asserts.sv ----
/*
 * Port-level assertions for the 16-bit counter unit.
 * Assumes the system clock domain and its async active-low reset.
 */
`timescale 1ns/1ns
`default_nettype none

module counter16_asserts
    import counter16_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic io_low_sel_in,
    input wire logic io_high_sel_in,
    input wire logic io_rd_in,
    input wire logic io_wr_in,
    input wire logic [7:0] io_wdata_in,
    input wire logic [7:0] io_rdata_out,
    input wire logic [2:0] clock_select_field_in,
    input wire logic [3:0] waveform_mode_field_in,
    input wire logic [7:0] temp_byte_out,
    input wire logic [15:0] timer_count_value_out,
    input wire logic timer_clock_out,
    input wire logic top_out,
    input wire logic bottom_out,
    input wire logic direction_down_out,
    input wire logic overflow_flag_out,
    input wire logic overflow_irq_en_in,
    input wire logic overflow_irq_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // Short name for the counter keeps the properties readable
    logic [15:0] cnt;
    assign cnt = timer_count_value_out;

    // ----------------------------------------
    // Access and count steps
    // ----------------------------------------
    sequence s_low_wr;
        ce_in && io_low_sel_in && io_wr_in;
    endsequence
    // A low write in the same cycle swallows the tick
    sequence s_tick;
        ce_in && timer_clock_out && !(io_low_sel_in && io_wr_in);
    endsequence
    sequence s_tick_norm;
        s_tick ##0 (waveform_mode_field_in == 4'h0);
    endsequence
    sequence s_rd(sel, oth);
        ce_in && sel && io_rd_in && !io_wr_in && !oth;
    endsequence

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_low_write_load: assert property (s_low_wr |=>
        cnt == {$past(temp_byte_out), $past(io_wdata_in)}) else $error("low write load wrong");
    a_low_read_copy: assert property (s_rd(io_low_sel_in, io_high_sel_in) |=>
        {temp_byte_out, io_rdata_out} == $past(cnt)) else $error("low read copy wrong");
    a_high_read_temp: assert property (s_rd(io_high_sel_in, io_low_sel_in) |=>
        io_rdata_out == $past(temp_byte_out)) else $error("high read not temp");
    a_high_write_temp: assert property (ce_in && io_high_sel_in && io_wr_in |=>
        temp_byte_out == $past(io_wdata_in)) else $error("high write missed temp");
    a_stop_no_tick: assert property (clock_select_field_in == CS_NONE |->
        !timer_clock_out) else $error("tick with no source");
    a_idle_hold: assert property (!(ce_in && (timer_clock_out || io_low_sel_in && io_wr_in))
        |=> $stable(cnt)) else $error("counter moved while idle");
    a_bottom_zero: assert property (bottom_out == (cnt == BOTTOM_VALUE))
        else $error("bottom wrong");
    a_top_fast8: assert property (waveform_mode_field_in == 4'h5 |->
        top_out == (cnt == TOP_FIX8)) else $error("top wrong");
    a_norm_step: assert property (s_tick_norm ##1 s_tick_norm |=>
        cnt == $past(cnt, 2) + 16'h0002) else $error("count step wrong");
    a_ovf_set: assert property (s_tick_norm ##0 (cnt == MAX_VALUE) |=>
        overflow_flag_out) else $error("overflow not flagged");
    a_irq_mask: assert property (overflow_irq_out ==
        (overflow_flag_out && overflow_irq_en_in)) else $error("irq mask wrong");
    a_dual_turn: assert property (s_tick ##0 (waveform_mode_field_in == 4'h1 &&
        cnt == TOP_FIX8) |=> direction_down_out && cnt == 16'h00FE) else $error("no turn");
    a_fast_clear: assert property (s_tick ##0 (waveform_mode_field_in == 4'h5 &&
        cnt == TOP_FIX8) |=> cnt == 16'h0000) else $error("no clear at top");
endmodule : counter16_asserts

bind counter16_byte_access_unit counter16_asserts u_chk (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .io_low_sel_in(io_low_sel_in), .io_high_sel_in(io_high_sel_in),
    .io_rd_in(io_rd_in), .io_wr_in(io_wr_in), .io_wdata_in(io_wdata_in),
    .io_rdata_out(io_rdata_out), .clock_select_field_in(clock_select_field_in),
    .waveform_mode_field_in(waveform_mode_field_in), .temp_byte_out(temp_byte_out),
    .timer_count_value_out(timer_count_value_out), .timer_clock_out(timer_clock_out),
    .top_out(top_out), .bottom_out(bottom_out), .direction_down_out(direction_down_out),
    .overflow_flag_out(overflow_flag_out), .overflow_irq_en_in(overflow_irq_en_in),
    .overflow_irq_out(overflow_irq_out)
);

`default_nettype wire

// ---- verification/cpu_io_model.sv ----
/*
 * CPU side of the 8-bit I/O port: single byte accesses and word writes.
 * Assumes requests are taken on the rising clock edge, read data a cycle later.
 */
`timescale 1ns/1ns
`default_nettype none

module cpu_io_model (
    input wire logic core_clk_in,
    input wire logic [7:0] rdata_in,
    output logic low_sel_out,
    output logic high_sel_out,
    output logic rd_out,
    output logic wr_out,
    output logic [7:0] wdata_out
);
    initial begin
        {low_sel_out, high_sel_out, rd_out, wr_out} = 4'h0;
        wdata_out = 8'h00;
    end

    // One byte access; callers are serial, so no other access splits a pair
    task automatic access(input logic hi, input logic wr, input logic [7:0] d,
                          output logic [7:0] q);
        @(posedge core_clk_in);
        high_sel_out <= hi;
        low_sel_out <= !hi;
        wr_out <= wr;
        rd_out <= !wr;
        wdata_out <= d;
        @(posedge core_clk_in);
        {low_sel_out, high_sel_out, rd_out, wr_out} <= 4'h0;
        wdata_out <= ~d; // A released bus must not keep its last value
        #1 q = rdata_in;
    endtask : access

    // Word write goes high byte first
    task automatic wr16(input logic [15:0] v);
        logic [7:0] q;
        access(1'b1, 1'b1, v[15:8], q);
        access(1'b0, 1'b1, v[7:0], q);
    endtask : wr16
endmodule : cpu_io_model

`default_nettype wire

// ---- verification/tb_counter16_byte_access_unit.sv ----
/*
 * Self-checking bench for the 16-bit counter unit, driven through cpu_io_model.
 * Assumes a 50 MHz system clock and the design's one-cycle read latency.
 */
`timescale 1ns/1ns
`default_nettype none

module tb_counter16_byte_access_unit
    import counter16_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, pin = 1'b0, tl = 1'b0;
    logic clr = 1'b0, ack = 1'b0, irq_en = 1'b1, lsel, hsel, rd, wr;
    logic [2:0] cs = 3'h0;
    logic [3:0] mode = 4'h0;
    logic [15:0] cmpa = 16'h0000, capt = 16'h0000, cnt;
    logic [7:0] tl_data = 8'h00, wdata, rdata, temp, q;
    logic tclk, top, bottom, down, ovf, irq;
    int n_mismatch = 0, n_tests = 0, cyc = 0;
    logic [3:0] fm [5] = '{4'h5, 4'h6, 4'h7, 4'hF, 4'hE};
    logic [15:0] ft [5] = '{16'h00FF, 16'h01FF, 16'h03FF, 16'h1234, 16'h0456};

    counter16_byte_access_unit dut (
        .core_clk_in(clk), .rst_n_in(rst_n), .ce_in(ce), .io_low_sel_in(lsel),
        .io_high_sel_in(hsel), .io_rd_in(rd), .io_wr_in(wr), .io_wdata_in(wdata),
        .io_rdata_out(rdata), .clock_select_field_in(cs), .waveform_mode_field_in(mode),
        .ext_clock_pin_in(pin), .compare_a_in(cmpa), .capture_in(capt),
        .temp_load_in(tl), .temp_load_data_in(tl_data), .temp_byte_out(temp),
        .overflow_clear_in(clr), .overflow_ack_in(ack), .overflow_irq_en_in(irq_en),
        .timer_count_value_out(cnt), .timer_clock_out(tclk), .top_out(top),
        .bottom_out(bottom), .direction_down_out(down), .overflow_flag_out(ovf),
        .overflow_irq_out(irq)
    );

    cpu_io_model cpu (
        .core_clk_in(clk), .rdata_in(rdata), .low_sel_out(lsel), .high_sel_out(hsel),
        .rd_out(rd), .wr_out(wr), .wdata_out(wdata)
    );

    // ----------------------------------------
    // Clock, timeout and reporting
    // ----------------------------------------
    initial begin
        forever #10 clk = ~clk;
    end

    // The longest stretch is the prescaler sweep, about 5125 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 12000) begin
            n_mismatch++;
            test_done();
        end
    end

    // Wide enough that packed flag, temp and counter groups are compared whole
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic test_done;
        $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done

    // Hold a clock source for exactly n edges, then stop it
    task automatic ticks(input logic [2:0] c, input int n);
        @(posedge clk) cs <= c;
        repeat (n) @(posedge clk);
        cs <= 3'h0;
        #1;
    endtask : ticks

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        #1 chk({temp, cnt}, 24'h0);
        chk({ovf, bottom, down}, 3'b010);
        repeat (8) @(posedge clk);
        #1 chk(cnt, 16'h0000);
        cpu.access(1'b1, 1'b1, 8'h01, q);
        chk({temp, cnt}, 24'h010000);
        cpu.access(1'b0, 1'b1, 8'hFF, q);
        chk(cnt, 16'h01FF);
        // Low read must refresh temp over a stale high write
        cpu.access(1'b1, 1'b1, 8'h55, q);
        cpu.access(1'b0, 1'b0, 8'h00, q);
        chk({temp, q}, 16'h01FF);
        cpu.access(1'b1, 1'b0, 8'h00, q);
        chk(q, 8'h01);
        cpu.access(1'b1, 1'b1, 8'h34, q);
        cpu.access(1'b0, 1'b1, 8'h01, q);
        chk(cnt, 16'h3401);
        cpu.access(1'b0, 1'b1, 8'h02, q);
        chk(cnt, 16'h3402);
        @(posedge clk) tl <= 1'b1;
        tl_data <= 8'h77;
        @(posedge clk) tl <= 1'b0;
        cpu.access(1'b0, 1'b1, 8'h10, q);
        chk(cnt, 16'h7710);
        // Normal mode wraps through MAX and raises the flag
        cpu.wr16(16'hFFFE);
        ticks(3'h1, 3);
        chk({ovf, irq, cnt}, 18'h30001);
        @(posedge clk) irq_en <= 1'b0;
        #1 chk(irq, 1'b0);
        @(posedge clk) ack <= 1'b1;
        @(posedge clk) ack <= 1'b0;
        #1 chk(ovf, 1'b0);
        // A low write lands exactly even while counting
        @(posedge clk) cs <= 3'h1;
        cpu.wr16(16'h2000);
        chk(cnt, 16'h2000);
        @(posedge clk) cs <= 3'h0;
        #1 chk(cnt, 16'h2001);
        // Whole prescaler periods give exact tick counts
        cpu.wr16(16'h0000);
        for (int i = 1; i <= 5; i++) begin
            ticks(3'(i), 1024);
        end
        chk(cnt, 16'h0495);
        @(posedge clk) cs <= 3'h7;
        @(posedge clk) pin <= 1'b1;
        repeat (3) @(posedge clk);
        cs <= 3'h6;
        pin <= 1'b0;
        repeat (3) @(posedge clk);
        cs <= 3'h0;
        #1 chk(cnt, 16'h0497);
        // Fast single-slope modes clear at each TOP source
        @(posedge clk) cmpa <= 16'h1234;
        capt <= 16'h0456;
        for (int i = 0; i < 5; i++) begin
            @(posedge clk) mode <= fm[i];
            cpu.wr16(ft[i]);
            chk(top, 1'b1);
            ticks(3'h1, 1);
            chk({ovf, cnt}, 17'h10000);
            @(posedge clk) clr <= 1'b1;
            @(posedge clk) clr <= 1'b0;
            #1 chk(ovf, 1'b0);
        end
        // Dual slope turns at TOP and flags at BOTTOM
        @(posedge clk) mode <= 4'h1;
        cpu.wr16(16'h00FE);
        ticks(3'h1, 2);
        chk({down, cnt}, 17'h100FE);
        cpu.wr16(16'h0001);
        ticks(3'h1, 2);
        chk({ovf, down, cnt}, 18'h20001);
        // Clock enable low freezes counting even with a source selected
        @(posedge clk) ce <= 1'b0;
        cs <= 3'h1;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
        cs <= 3'h0;
        #1 chk(cnt, 16'h0001);
        // A reset in mid-run clears the flag and the counter again
        @(posedge clk) rst_n <= 1'b0;
        @(posedge clk) rst_n <= 1'b1;
        #1 chk({ovf, cnt}, 17'h0);
        test_done();
    end
endmodule : tb_counter16_byte_access_unit

`default_nettype wire
